// *** hw/dsm_map.svh ***
// dsm_map.svh: offsets, field positions, reset values and counts
// assumes: included by bare name from the module files
`ifndef DSM_MAP_SVH
`define DSM_MAP_SVH
// base mode setting word fields
`define DSM_MODE_RST    14'h0021
`define DSM_BL_HI       2
`define DSM_BL_LO       0
`define DSM_BT_BIT      3
`define DSM_CL_HI       6
`define DSM_CL_LO       4
`define DSM_OPM_BIT     7
`define DSM_DLLRST_BIT  8
`define DSM_APRE_BIT    10
// field codes
`define DSM_BL2         3'h1
`define DSM_BL4         3'h2
`define DSM_BL8         3'h3
`define DSM_CL2         3'h2
`define DSM_CL25        3'h6
// read latency in half clocks
`define DSM_CL2_HALVES  5'h04
`define DSM_CL25_HALVES 5'h05
// write buffer
`define DSM_WBUF_DEPTH  32
`define DSM_WBUF_ROOM   6'h1d
// presence-detect device type
`define DSM_SPD_TYPE    4'ha
`endif

// *** hw/dsm_pkg.sv ***
// dsm_pkg: types shared by the module files
// assumes: used by scoped name only
package dsm_pkg;
	// commands as {ras_n, cas_n, we_n}
	typedef enum logic [2:0] {
		CMD_MRS = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010,
		CMD_ACT = 3'b011, CMD_WR = 3'b100, CMD_RD = 3'b101,
		CMD_BST = 3'b110, CMD_NOP = 3'b111
	} dsm_cmd_t;
	// presence-detect serial slave states
	typedef enum logic [2:0] {
		SPD_IDLE = 3'b000, SPD_DEV = 3'b001, SPD_PTR = 3'b010,
		SPD_WDAT = 3'b011, SPD_RDAT = 3'b100, SPD_ACK = 3'b101,
		SPD_RACK = 3'b110
	} dsm_spd_st_t;
endpackage

// *** hw/dsm_fifo.sv ***
// dsm_fifo: write data buffer, valid/ready on both sides
// assumes: one clock, reset already synchronised
`timescale 1ns/1ns
module dsm_fifo #(
	parameter int W = 34,
	parameter int D = 32
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_valid,
	output logic                      o_ready,
	input  wire logic [W-1:0]         i_data,
	output logic                      o_valid,
	input  wire logic                 i_ready,
	output logic [W-1:0]              o_data,
	output logic [$clog2(D):0]        o_level
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];   // storage, no reset needed
	logic [AW:0]  wp_q;      // write pointer with wrap bit
	logic [AW:0]  rp_q;      // read pointer with wrap bit

	assign o_level = wp_q - rp_q;
	assign o_ready = o_level != (AW+1)'(D);
	assign o_valid = wp_q != rp_q;
	assign o_data  = mem[rp_q[AW-1:0]];

	// pointers
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			if (i_valid && o_ready)
				wp_q <= wp_q + 1'b1;
			if (o_valid && i_ready)
				rp_q <= rp_q + 1'b1;
		end
	end

	// storage write
	always_ff @(posedge i_clk)
	begin
		if (i_valid && o_ready)
			mem[wp_q[AW-1:0]] <= i_data;
	end

	a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(!o_ready |=> o_level <= (AW+1)'(D)))
		else $error("write buffer level beyond depth");
endmodule

// *** hw/dsm_spd.sv ***
// dsm_spd: presence-detect store with two-wire serial slave
// assumes: scl and sda already synchronous to i_clk
`timescale 1ns/1ns
`include "dsm_map.svh"
module dsm_spd (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic [2:0] i_sa,
	output logic            o_sda_o,
	output logic            o_sda_oe
);
	logic [7:0] mem [256];              // 256 bytes
	logic                 scl_q;
	logic                 sda_q;
	logic [7:0]           sr_q;         // shift register
	logic [7:0]           ptr_q;        // byte pointer
	logic [3:0]           cnt_q;        // bit count
	dsm_pkg::dsm_spd_st_t st_q;
	dsm_pkg::dsm_spd_st_t nxt_q;        // state after ack slot
	logic start, stop, rise, fall, wr_en;

	assign start = scl_q & i_scl & sda_q & ~i_sda;
	assign stop  = scl_q & i_scl & ~sda_q & i_sda;
	assign rise  = ~scl_q & i_scl;
	assign fall  = scl_q & ~i_scl;
	// protect pin is grounded: writes always land
	assign wr_en = fall && st_q == dsm_pkg::SPD_WDAT && cnt_q == 4'h8;

	// byte store
	always_ff @(posedge i_clk)
	begin
		if (wr_en)
			mem[ptr_q] <= sr_q;
	end

	// bus protocol
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			sr_q <= 8'h00;
			ptr_q <= 8'h00;
			cnt_q <= 4'h0;
			st_q <= dsm_pkg::SPD_IDLE;
			nxt_q <= dsm_pkg::SPD_IDLE;
			o_sda_oe <= 1'b0;
			o_sda_o <= 1'b0;
		end
		else
		begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			if (start)
			begin
				st_q <= dsm_pkg::SPD_DEV;
				cnt_q <= 4'h0;
				o_sda_oe <= 1'b0;
			end
			else if (stop)
			begin
				st_q <= dsm_pkg::SPD_IDLE;
				o_sda_oe <= 1'b0;
			end
			else if (rise)
			begin
				// receive a bit or the master's acknowledge
				if (st_q == dsm_pkg::SPD_RACK)
				begin
					st_q <= i_sda ? dsm_pkg::SPD_IDLE : dsm_pkg::SPD_ACK;
					nxt_q <= dsm_pkg::SPD_RDAT;
				end
				else if (st_q != dsm_pkg::SPD_IDLE && st_q != dsm_pkg::SPD_ACK
					&& st_q != dsm_pkg::SPD_RDAT && cnt_q != 4'h8)
				begin
					sr_q <= {sr_q[6:0], i_sda};
					cnt_q <= cnt_q + 4'h1;
				end
			end
			else if (fall)
			begin
				unique case (st_q)
					dsm_pkg::SPD_DEV:
						if (cnt_q == 4'h8)
						begin
							// eight addresses by strap
							if (sr_q[7:1] == {`DSM_SPD_TYPE, i_sa})
							begin
								o_sda_oe <= 1'b1;
								st_q <= dsm_pkg::SPD_ACK;
								nxt_q <= sr_q[0] ? dsm_pkg::SPD_RDAT
									: dsm_pkg::SPD_PTR;
							end
							else
								st_q <= dsm_pkg::SPD_IDLE;
						end
					dsm_pkg::SPD_PTR, dsm_pkg::SPD_WDAT:
						if (cnt_q == 4'h8)
						begin
							ptr_q <= (st_q == dsm_pkg::SPD_PTR) ? sr_q
								: ptr_q + 8'h01;
							o_sda_oe <= 1'b1;
							st_q <= dsm_pkg::SPD_ACK;
							nxt_q <= dsm_pkg::SPD_WDAT;
						end
					dsm_pkg::SPD_ACK:
					begin
						// release the line, load the next byte on reads
						o_sda_oe <= 1'b0;
						cnt_q <= 4'h0;
						st_q <= nxt_q;
						if (nxt_q == dsm_pkg::SPD_RDAT)
						begin
							sr_q <= mem[ptr_q];
							ptr_q <= ptr_q + 8'h01;
							o_sda_oe <= ~mem[ptr_q][7];
						end
					end
					dsm_pkg::SPD_RDAT:
						if (cnt_q == 4'h7)
						begin
							st_q <= dsm_pkg::SPD_RACK;
							o_sda_oe <= 1'b0;
						end
						else
						begin
							sr_q <= {sr_q[6:0], 1'b0};
							cnt_q <= cnt_q + 4'h1;
							o_sda_oe <= ~sr_q[6];
						end
					default:
						st_q <= st_q;
				endcase
			end
		end
	end
endmodule

// *** hw/dsm_ddr_module.sv ***
// dsm_ddr_module: command, burst and mode logic of a ddr memory module
// assumes: controller keeps its own ordering; pins sampled on i_sys_clk,
// each clock carries a rise half and a fall half of the data bus
`timescale 1ns/1ns
`include "dsm_map.svh"
// Notes on behaviour
// - two words per clock, one core pair
// - strobe driven only with read data
// - commands registered on every rising edge
// - write data on both strobe edges
// - activate takes bank and row
// - read or write takes bank and column
// - burst of 2, 4 or 8 both ways
// - auto precharge closes row after burst
// - presence store holds 256 bytes
// - serial slave, three address straps
// - presence store never write protected
// - mode set with bank zero, kept
// - dll reset bit clears itself
// - mode set leaves array untouched
// - mode fields: length, type, latency, mode
// - burst wraps inside aligned block
// - low column bits pick start
// - order select bit picks ordering
// - read latency two or two and half
// - first read data at edge n+m
// - all mode bits zero: normal
// - only bit eight set: dll reset
module dsm_ddr_module (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_cs_n,
	input  wire logic        i_ras_n,
	input  wire logic        i_cas_n,
	input  wire logic        i_we_n,
	input  wire logic [1:0]  i_ba,
	input  wire logic [13:0] i_addr,
	input  wire logic [7:0]  i_dq_rise,
	input  wire logic [7:0]  i_dq_fall,
	input  wire logic        i_dm_rise,
	input  wire logic        i_dm_fall,
	input  wire logic        i_dqs_rise,
	input  wire logic        i_dqs_fall,
	output logic [7:0]       o_dq_rise,
	output logic [7:0]       o_dq_fall,
	output logic [1:0]       o_dq_oe,
	output logic [1:0]       o_dqs_o,
	output logic [1:0]       o_dqs_oe,
	output logic [3:0]       o_bank_open,
	output logic             o_dll_reset,
	output logic             o_wbuf_ready,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic [2:0]  i_sa,
	output logic             o_sda_o,
	output logic             o_sda_oe
);
	// burst length in beats from its code; reserved codes act as two
	function automatic logic [3:0] bl_len(input logic [2:0] code);
		case (code)
			`DSM_BL4: bl_len = 4'h4;
			`DSM_BL8: bl_len = 4'h8;
			default:  bl_len = 4'h2;
		endcase
	endfunction

	// column of beat k inside the aligned block
	function automatic logic [3:0] burst_col(input logic [3:0] start,
		input logic [2:0] k, input logic [2:0] code, input logic bt);
		logic [2:0] mask;
		logic [2:0] off;
		mask = (code == `DSM_BL8) ? 3'h7 : (code == `DSM_BL4) ? 3'h3 : 3'h1;
		off = bt ? (start[2:0] ^ k) : (start[2:0] + k);
		burst_col = {start[3], (start[2:0] & ~mask) | (off & mask)};
	endfunction

	logic [1:0]         rst_sync_q;   // reset release pipeline
	logic               rst_n;        // synchronised reset
	dsm_pkg::dsm_cmd_t  cmd;          // decoded command this edge
	logic [13:0]        mode_q;       // base_mode_setting
	logic [2:0]         bl_code;
	logic               bt;           // burst_order_select_bit
	logic [3:0]         bl;
	logic [4:0]         lat_half;     // read latency in half clocks
	logic               mrs0;
	logic [3:0]         open_q;       // bank has an open row
	logic [13:0]        row_q [4];    // open row per bank
	logic               rd_go;
	logic               wr_go;
	logic [7:0]         mem_q [256];  // model array, 8-bit words

	// reset release
	always_ff @(posedge i_sys_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// command decode straight off the pins
	assign cmd = i_cs_n ? dsm_pkg::CMD_NOP
		: dsm_pkg::dsm_cmd_t'({i_ras_n, i_cas_n, i_we_n});
	assign mrs0 = cmd == dsm_pkg::CMD_MRS && i_ba == 2'b00;
	// accesses to a closed bank are dropped
	assign rd_go = cmd == dsm_pkg::CMD_RD && open_q[i_ba];
	assign wr_go = cmd == dsm_pkg::CMD_WR && open_q[i_ba];

	// mode field decode
	assign bl_code = mode_q[`DSM_BL_HI:`DSM_BL_LO];
	assign bt = mode_q[`DSM_BT_BIT];
	assign bl = bl_len(bl_code);
	assign lat_half = (mode_q[`DSM_CL_HI:`DSM_CL_LO] == `DSM_CL25)
		? `DSM_CL25_HALVES : `DSM_CL2_HALVES;

	// mode setting: bank zero only, reserved operating modes ignored
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			mode_q <= `DSM_MODE_RST;
		else if (mrs0 && i_addr[13:9] == 5'h00 && !i_addr[`DSM_OPM_BIT])
			mode_q <= i_addr;
		else
			mode_q[`DSM_DLLRST_BIT] <= 1'b0;
	end
	assign o_dll_reset = mode_q[`DSM_DLLRST_BIT];

	// read burst state
	logic               rd_act_q;
	logic signed [4:0]  pos_q;        // beat index of this cycle's rise half
	logic [1:0]         rd_ba_q;
	logic [1:0]         rd_row_q;
	logic [3:0]         rd_col_q;
	logic               rd_ap_q;
	logic signed [4:0]  pr;
	logic signed [4:0]  pf;
	logic signed [4:0]  bls;
	logic               vr;
	logic               vf;
	logic               rd_end;
	logic [3:0]         col_r;
	logic [3:0]         col_f;

	assign pr = pos_q + 5'sh02;
	assign pf = pos_q + 5'sh03;
	assign bls = signed'({1'b0, bl});
	assign vr = rd_act_q && pr >= 5'sh00 && pr < bls;
	assign vf = rd_act_q && pf >= 5'sh00 && pf < bls;
	assign rd_end = rd_act_q && pf >= bls - 5'sh01;
	assign col_r = burst_col(rd_col_q, pr[2:0], bl_code, bt);
	assign col_f = burst_col(rd_col_q, pf[2:0], bl_code, bt);

	// read burst tracking; a new read restarts the pipeline
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_act_q <= 1'b0;
			pos_q <= 5'sh00;
			rd_ba_q <= 2'h0;
			rd_row_q <= 2'h0;
			rd_col_q <= 4'h0;
			rd_ap_q <= 1'b0;
		end
		else if (rd_go)
		begin
			// first beat lands lat_half halves later
			rd_act_q <= 1'b1;
			pos_q <= -signed'(lat_half);
			rd_ba_q <= i_ba;
			rd_row_q <= row_q[i_ba][1:0];
			rd_col_q <= i_addr[3:0];
			rd_ap_q <= i_addr[`DSM_APRE_BIT];
		end
		else if (rd_end)
			rd_act_q <= 1'b0;
		else if (rd_act_q)
			pos_q <= pos_q + 5'sh02;
	end

	// read data and edge-aligned strobe, two words a clock
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_dq_rise <= 8'h00;
			o_dq_fall <= 8'h00;
			o_dq_oe <= 2'b00;
			o_dqs_oe <= 2'b00;
			o_dqs_o <= 2'b00;
		end
		else
		begin
			o_dq_rise <= mem_q[{rd_ba_q, rd_row_q, col_r}];
			o_dq_fall <= mem_q[{rd_ba_q, rd_row_q, col_f}];
			o_dq_oe <= {vf, vr};
			o_dqs_oe <= {vf, vr};
			o_dqs_o <= 2'b01;
		end
	end

	// write burst state
	logic               wr_act_q;
	logic [3:0]         wk_q;         // beats taken so far
	logic [1:0]         wr_ba_q;
	logic [1:0]         wr_row_q;
	logic [3:0]         wr_col_q;
	logic               wr_ap_q;
	logic [3:0]         kf;
	logic [3:0]         wk_n;
	logic               tr;
	logic               tf;
	logic               wr_end;
	logic [33:0]        wb_in;
	logic [33:0]        wb_out;
	logic               wb_in_ready;
	logic               wb_valid;
	logic [5:0]         wb_level;
	logic               drain_ready;

	assign kf = wk_q + {3'h0, i_dqs_rise};
	assign wk_n = kf + {3'h0, i_dqs_fall};
	// a beat per strobe edge, up to the burst length
	assign tr = wr_act_q && i_dqs_rise && wk_q < bl;
	assign tf = wr_act_q && i_dqs_fall && kf < bl;
	assign wr_end = wr_act_q && wk_n >= bl;
	// masked beats still count but do not write
	assign wb_in = {tr & ~i_dm_rise, wr_ba_q, wr_row_q,
		burst_col(wr_col_q, wk_q[2:0], bl_code, bt), i_dq_rise,
		tf & ~i_dm_fall, wr_ba_q, wr_row_q,
		burst_col(wr_col_q, kf[2:0], bl_code, bt), i_dq_fall};

	// write burst tracking, data expected from the next clock on
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_act_q <= 1'b0;
			wk_q <= 4'h0;
			wr_ba_q <= 2'h0;
			wr_row_q <= 2'h0;
			wr_col_q <= 4'h0;
			wr_ap_q <= 1'b0;
		end
		else if (wr_go)
		begin
			wr_act_q <= 1'b1;
			wk_q <= 4'h0;
			wr_ba_q <= i_ba;
			wr_row_q <= row_q[i_ba][1:0];
			wr_col_q <= i_addr[3:0];
			wr_ap_q <= i_addr[`DSM_APRE_BIT];
		end
		else if (wr_end)
			wr_act_q <= 1'b0;
		else
			wk_q <= wk_n;
	end

	// row state per bank
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			open_q <= 4'h0;
		else
		begin
			if (cmd == dsm_pkg::CMD_ACT)
				open_q[i_ba] <= 1'b1;
			else if (cmd == dsm_pkg::CMD_PRE)
			begin
				if (i_addr[`DSM_APRE_BIT])
					open_q <= 4'h0;
				else
					open_q[i_ba] <= 1'b0;
			end
			// self-timed precharge at burst end
			if (rd_end && rd_ap_q)
				open_q[rd_ba_q] <= 1'b0;
			if (wr_end && wr_ap_q)
				open_q[wr_ba_q] <= 1'b0;
		end
	end
	assign o_bank_open = open_q;

	// open row address; data-like, left without reset
	always_ff @(posedge i_sys_clk)
	begin
		if (cmd == dsm_pkg::CMD_ACT)
			row_q[i_ba] <= i_addr;
	end

	// write buffer; the array port is shared, reads take it first
	assign drain_ready = !rd_act_q;
	dsm_fifo #(
		.W (34),
		.D (`DSM_WBUF_DEPTH)
	) u_wbuf (
		.i_clk   (i_sys_clk),
		.i_rst_n (rst_n),
		.i_valid (tr | tf),
		.o_ready (wb_in_ready),
		.i_data  (wb_in),
		.o_valid (wb_valid),
		.i_ready (drain_ready),
		.o_data  (wb_out),
		.o_level (wb_level)
	);

	// headroom flag leaves room for the cycle it takes to be seen
	always_ff @(posedge i_sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			o_wbuf_ready <= 1'b0;
		else
			o_wbuf_ready <= wb_in_ready && wb_level <= `DSM_WBUF_ROOM;
	end

	// array write: only buffered write beats, never a mode set
	always_ff @(posedge i_sys_clk)
	begin
		if (wb_valid && drain_ready)
		begin
			if (wb_out[33])
				mem_q[wb_out[32:25]] <= wb_out[24:17];
			if (wb_out[16])
				mem_q[wb_out[15:8]] <= wb_out[7:0];
		end
	end

	// presence-detect store and serial slave
	dsm_spd u_spd (
		.i_clk    (i_sys_clk),
		.i_rst_n  (rst_n),
		.i_scl    (i_scl),
		.i_sda    (i_sda),
		.i_sa     (i_sa),
		.o_sda_o  (o_sda_o),
		.o_sda_oe (o_sda_oe)
	);

	// checks
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_rd_cl2;
		rd_go && lat_half == `DSM_CL2_HALVES;
	endsequence
	sequence s_rd_cl25;
		rd_go && lat_half == `DSM_CL25_HALVES;
	endsequence
	sequence s_quiet;
		(!rd_go)[*2];
	endsequence

	a_read_cl2: assert property (s_rd_cl2 ##1 s_quiet |=> o_dq_oe == 2'b11)
		else $error("latency two read data not at edge n+2");
	a_read_cl25: assert property (s_rd_cl25 ##1 s_quiet |=> o_dq_oe == 2'b10)
		else $error("latency two and half data not at fall of n+2");
	a_strobe_data: assert property (o_dqs_oe == o_dq_oe && (o_dqs_oe == 2'b00 || o_dqs_o == 2'b01))
		else $error("strobe not edge aligned with read data");
	// any legal dll reset mode set, whatever length and latency it carries
	a_dll_clear: assert property (mrs0 && i_addr[13:7] == 7'h02
		|=> mode_q[`DSM_DLLRST_BIT] ##1 !mode_q[`DSM_DLLRST_BIT])
		else $error("dll reset bit did not clear itself");
	a_mode_keep: assert property (!mrs0 && !mode_q[8] |=> $stable(mode_q))
		else $error("mode setting changed without a mode set");
	a_act_opens: assert property (cmd == dsm_pkg::CMD_ACT |=> open_q[$past(i_ba)])
		else $error("activate did not open the bank");
	a_block_wrap: assert property (vr |-> ((col_r ^ rd_col_q) & ~(bl - 4'h1)) == 4'h0)
		else $error("read beat left its aligned block");
	a_apre_close: assert property (rd_end && rd_ap_q && !rd_go && cmd != dsm_pkg::CMD_ACT |=> !open_q[$past(rd_ba_q)])
		else $error("auto precharge left the row open");
endmodule

// *** tb/dsm_ctl_model.sv ***
// dsm_ctl_model: controller stand-in for command and write data pins
// assumes: the device samples every pin on the rising edge of i_sys_clk
`timescale 1ns/1ns
module dsm_ctl_model (
	input  wire logic   i_sys_clk,
	output logic        o_cs_n,
	output logic        o_ras_n,
	output logic        o_cas_n,
	output logic        o_we_n,
	output logic [1:0]  o_ba,
	output logic [13:0] o_addr,
	output logic [7:0]  o_dq_rise,
	output logic [7:0]  o_dq_fall,
	output logic        o_dm_rise,
	output logic        o_dm_fall,
	output logic        o_dqs_rise,
	output logic        o_dqs_fall
);
	// bus idle at time zero, nothing masked
	initial
	begin
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
		o_ba = 2'h0;
		o_addr = 14'h0000;
		{o_dq_rise, o_dq_fall} = 16'h5aa5;
		{o_dm_rise, o_dm_fall, o_dqs_rise, o_dqs_fall} = 4'h0;
	end

	// one command held across exactly one rising edge
	task cmd(input logic [2:0] c, input logic [1:0] ba,
		input logic [13:0] a);
		@(negedge i_sys_clk);
		o_cs_n = 1'b0;
		{o_ras_n, o_cas_n, o_we_n} = c;
		o_ba = ba;
		o_addr = a;
		@(negedge i_sys_clk);
		{o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
		// released lines must not keep showing the last value
		o_addr = ~a;
	endtask

	// write burst, two beats a clock, rise beat first
	// msk bit k high masks beat k
	task wr(input logic [1:0] ba, input logic [2:0] col, input int bl,
		input logic [7:0] base, input logic [7:0] msk);
		cmd(dsm_pkg::CMD_WR, ba, {11'h000, col});
		for (int i = 0; i < bl; i += 2)
		begin
			{o_dqs_rise, o_dqs_fall} = 2'h3;
			o_dq_rise = base + 8'(i);
			o_dq_fall = base + 8'(i + 1);
			{o_dm_rise, o_dm_fall} = {msk[i], msk[i + 1]};
			@(negedge i_sys_clk);
		end
		// strobe only inside the write burst
		{o_dqs_rise, o_dqs_fall} = 2'h0;
		{o_dm_rise, o_dm_fall} = 2'h0;
		{o_dq_rise, o_dq_fall} = ~{o_dq_rise, o_dq_fall};
	endtask
endmodule

// *** tb/tb.sv ***
// tb: self-checking bench for burst, latency and mode logic
// assumes: dsm_ctl_model drives the controller side of the pins
`timescale 1ns/1ns
`include "dsm_map.svh"
module tb;
	logic        i_sys_clk;
	logic        i_rst_n;
	logic        cs_n, ras_n, cas_n, we_n, dm_r, dm_f, dqs_r, dqs_f;
	logic [1:0]  ba, o_dq_oe, o_dqs_o, o_dqs_oe;
	logic [13:0] addr;
	logic [7:0]  dq_r, dq_f, o_dq_rise, o_dq_fall;
	logic [3:0]  o_bank_open;
	logic        o_dll_reset, o_wbuf_ready, o_sda_o, o_sda_oe;
	logic        m_scl, m_sda, sda_line;
	int          mismatches = 0;
	int          checked = 0;

	// open-drain serial data with pull-up
	assign sda_line = (o_sda_oe ? o_sda_o : 1'b1) & m_sda;

	// 125 MHz clock
	initial
	begin
		i_sys_clk = 1'b0;
		forever #4 i_sys_clk = ~i_sys_clk;
	end

	dsm_ctl_model u_dsm_ctl_model (.i_sys_clk(i_sys_clk), .o_cs_n(cs_n),
		.o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba),
		.o_addr(addr), .o_dq_rise(dq_r), .o_dq_fall(dq_f), .o_dm_rise(dm_r),
		.o_dm_fall(dm_f), .o_dqs_rise(dqs_r), .o_dqs_fall(dqs_f));

	dsm_ddr_module u_dsm_ddr_module (.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
		.i_we_n(we_n), .i_ba(ba), .i_addr(addr), .i_dq_rise(dq_r),
		.i_dq_fall(dq_f), .i_dm_rise(dm_r), .i_dm_fall(dm_f),
		.i_dqs_rise(dqs_r), .i_dqs_fall(dqs_f), .o_dq_rise(o_dq_rise),
		.o_dq_fall(o_dq_fall), .o_dq_oe(o_dq_oe), .o_dqs_o(o_dqs_o),
		.o_dqs_oe(o_dqs_oe), .o_bank_open(o_bank_open),
		.o_dll_reset(o_dll_reset), .o_wbuf_ready(o_wbuf_ready),
		.i_scl(m_scl), .i_sda(sda_line), .i_sa(3'h3), .o_sda_o(o_sda_o),
		.o_sda_oe(o_sda_oe));

	// compare and count
	task check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			mismatches++;
		end
	endtask

	task print_verdict;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// mode set only with the bank closed, then bank 1 reopened
	task mode(input logic [2:0] bl, input logic bt, input logic [2:0] cl);
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_PRE, 2'h1, 14'h0000);
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_MRS, 2'h0,
			{7'h00, cl, bt, bl});
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_ACT, 2'h1, 14'h0000);
	endtask

	// read burst from bank 1; column c holds 8'h10 + c
	task rd(input logic [2:0] st, input int bl, input logic bt,
		input int h, input logic ap);
		logic [2:0] m;
		logic [2:0] c;
		int         k;
		m = 3'(bl - 1);
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_RD, 2'h1, {3'h0, ap, 7'h00, st});
		@(negedge i_sys_clk);
		// one slot per half clock, half-clock latency shifts by one slot
		for (int p = 0; p < bl + 2 * h; p++)
		begin
			if (p % 2 == 0)
				@(negedge i_sys_clk);
			k = p - h;
			c = (st & ~m) | (bt ? ((st & m) ^ 3'(k)) : ((st + 3'(k)) & m));
			check("read_oe", {7'h00, o_dq_oe[p % 2]},
				{7'h00, k >= 0 && k < bl});
			check("strobe_oe", {7'h00, o_dqs_oe[p % 2]},
				{7'h00, k >= 0 && k < bl});
			if (k >= 0 && k < bl)
				check("read_data", (p % 2) ? o_dq_fall : o_dq_rise,
					8'h10 + {5'h00, c});
		end
		@(negedge i_sys_clk);
		check("read_end", {6'h00, o_dq_oe}, 8'h00);
		// edge aligned: strobe high in the rise half, low in the fall half
		check("strobe_lvl", {6'h00, o_dqs_o}, 8'h01);
		check("row_open", {7'h00, o_bank_open[1]}, {7'h00, !ap});
	endtask

	// serial bit: four clocks of setup, scl high for four, then low for two
	task sbit(input logic b, output logic a);
		m_sda = b;
		repeat (4) @(negedge i_sys_clk);
		m_scl = 1'b1;
		repeat (2) @(negedge i_sys_clk);
		a = sda_line;
		repeat (2) @(negedge i_sys_clk);
		m_scl = 1'b0;
		repeat (2) @(negedge i_sys_clk);
	endtask

	// start condition: sda falls while scl is high
	task sstart;
		m_sda = 1'b0;
		repeat (4) @(negedge i_sys_clk);
		m_scl = 1'b0;
	endtask

	// one byte out, then the slave's acknowledge slot
	task sbyte(input logic [7:0] v, input logic ack);
		logic a;
		for (int i = 7; i >= 0; i--)
			sbit(v[i], a);
		sbit(1'b1, a);
		check("spd_ack", {7'h00, a}, {7'h00, !ack});
	endtask

	// one byte in, then acknowledge to go on or not to end
	task sread(input logic [7:0] exp, input logic more);
		logic       a;
		logic [7:0] v;
		for (int i = 7; i >= 0; i--)
		begin
			sbit(1'b1, a);
			v[i] = a;
		end
		sbit(!more, a);
		check("spd_data", v, exp);
	endtask

	// stop condition: sda rises while scl is high
	task sstop;
		m_sda = 1'b0;
		repeat (4) @(negedge i_sys_clk);
		m_scl = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		m_sda = 1'b1;
		repeat (4) @(negedge i_sys_clk);
	endtask

	// watchdog, far beyond the thousand or so cycles the tests need
	initial
	begin
		#200000;
		mismatches++;
		print_verdict;
	end

	// main sequence
	initial
	begin
		i_rst_n = 1'b0;
		m_scl = 1'b1;
		m_sda = 1'b1;
		repeat (20) @(negedge i_sys_clk);
		i_rst_n = 1'b1;
		repeat (4) @(negedge i_sys_clk);
		check("bank_idle", {4'h0, o_bank_open}, 8'h00);
		check("wbuf_ready", {7'h00, o_wbuf_ready}, 8'h01);
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_MRS, 2'h0,
			{5'h00, 1'b1, 1'b0, `DSM_CL2, 1'b0, `DSM_BL8});
		check("dll_pulse", {7'h00, o_dll_reset}, 8'h01);
		@(negedge i_sys_clk);
		check("dll_clear", {7'h00, o_dll_reset}, 8'h00);
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_ACT, 2'h1, 14'h0000);
		check("bank_open", {4'h0, o_bank_open}, 8'h02);
		u_dsm_ctl_model.wr(2'h1, 3'h0, 8, 8'h10, 8'h00);
		repeat (4) @(negedge i_sys_clk);
		rd(3'h3, 8, 1'b0, 0, 1'b0);
		// mode sets to the other bank or a reserved mode leave length 8
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_MRS, 2'h1, {11'h000, `DSM_BL2});
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_MRS, 2'h0,
			{6'h00, 1'b1, `DSM_CL2, 1'b0, `DSM_BL2});
		rd(3'h5, 8, 1'b0, 0, 1'b0);
		mode(`DSM_BL4, 1'b1, `DSM_CL2);
		rd(3'h5, 4, 1'b1, 0, 1'b0);
		mode(`DSM_BL2, 1'b0, `DSM_CL2);
		// fully masked two-beat write must leave columns 6 and 7 alone
		u_dsm_ctl_model.wr(2'h1, 3'h6, 2, 8'h20, 8'h03);
		rd(3'h7, 2, 1'b0, 0, 1'b0);
		mode(`DSM_BL4, 1'b0, `DSM_CL25);
		rd(3'h2, 4, 1'b0, 1, 1'b1);
		// read to the now closed bank is ignored
		u_dsm_ctl_model.cmd(dsm_pkg::CMD_RD, 2'h1, 14'h0002);
		repeat (2) @(negedge i_sys_clk);
		check("closed_rd", {6'h00, o_dq_oe}, 8'h00);
		// two bytes into the top of the store, pointer wraps after them
		sstart;
		sbyte(8'ha6, 1'b1);
		sbyte(8'hfe, 1'b1);
		sbyte(8'h3c, 1'b1);
		sbyte(8'hc3, 1'b1);
		sstop;
		// set the pointer back, then read both bytes
		sstart;
		sbyte(8'ha6, 1'b1);
		sbyte(8'hfe, 1'b1);
		sstop;
		sstart;
		sbyte(8'ha7, 1'b1);
		sread(8'h3c, 1'b1);
		sread(8'hc3, 1'b0);
		sstop;
		check("sda_level", {7'h00, o_sda_o}, 8'h00);
		// another strap setting must not answer
		sstart;
		sbyte(8'ha0, 1'b0);
		sstop;
		print_verdict;
	end
endmodule
